// >>> hw/acs_top.sv
// Accumulator saturation and overflow block with AXI4-Lite registers
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module acs_top
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ACS_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ACS_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  input wire logic [1:0] rresp_unused_guard,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Adder/subtracter result
  input wire logic res_valid,
  input wire acs_result_s res,
  // Accumulators and flags
  output logic [ACS_ACC_W-1:0] acc_a,
  output logic [ACS_ACC_W-1:0] acc_b,
  output acs_flags_s flags,
  // Trap and interrupt
  output logic trap_req,
  output logic irq
);

  // ----------------------------------------------------------------
  // Address decoding
  // ----------------------------------------------------------------

  // Map a byte address onto a register index; misses give NONE
  function automatic logic [3:0] acs_decode(input logic [5:0] addr);
    logic [3:0] idx;
    idx = ACS_IDX_NONE;
    if (addr == ACS_OFF_CTRL)
      idx = ACS_IDX_CTRL;
    else if (addr == ACS_OFF_STATUS)
      idx = ACS_IDX_STATUS;
    else if (addr == ACS_OFF_MASK)
      idx = ACS_IDX_MASK;
    else if (addr == ACS_OFF_FLAGS)
      idx = ACS_IDX_FLAGS;
    else if (addr == ACS_OFF_ACCA_LO)
      idx = ACS_IDX_ACCA_LO;
    else if (addr == ACS_OFF_ACCA_HI)
      idx = ACS_IDX_ACCA_HI;
    else if (addr == ACS_OFF_ACCB_LO)
      idx = ACS_IDX_ACCB_LO;
    else if (addr == ACS_OFF_ACCB_HI)
      idx = ACS_IDX_ACCB_HI;
    return idx;
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [ACS_CTRL_W-1:0] ctrl;  // Mode and trap enable bits
  logic [ACS_STAT_W-1:0] status;  // Sticky clamped and trap bits
  logic [ACS_STAT_W-1:0] mask;  // Interrupt mask, same layout
  logic ovf_a;  // Accumulator A overflow, per result
  logic ovf_b;  // Accumulator B overflow, per result
  logic [ACS_ADDR_W-1:0] wr_addr;  // Held write address
  logic [31:0] wr_data;  // Held write data
  logic [3:0] wr_strb;  // Held byte enables

  // Control fields
  wire sat_en_a = ctrl[0];
  wire sat_en_b = ctrl[1];
  wire sat_40_sel = ctrl[2];
  wire wrap_trap_enable = ctrl[3];

  // ----------------------------------------------------------------
  // Saturation datapath
  // ----------------------------------------------------------------

  // Target's enable picks clamping; select picks the limit
  wire tgt_sat_en = res.target ? sat_en_b : sat_en_a;
  wire acs_mode_e tgt_mode = !tgt_sat_en ? ACS_MODE_WRAP :
    (sat_40_sel ? ACS_MODE_SAT39 : ACS_MODE_SAT31);
  wire [ACS_ACC_W-1:0] sat_result;
  wire clamp_evt;
  wire ovf_evt;

  // One shared unit: only one accumulator is targeted per result
  acs_sat_unit u_sat (
    .sum(res.sum),
    .mode(tgt_mode),
    .result(sat_result),
    .clamp_evt(clamp_evt),
    .ovf_flag(ovf_evt)
  );

  // Events qualified by target
  wire set_a = res_valid & ~res.target & clamp_evt;
  wire set_b = res_valid & res.target & clamp_evt;
  // Trap only when clamping is off for the target
  wire trap_evt = res_valid & clamp_evt & ~tgt_sat_en &
    wrap_trap_enable;

  // ----------------------------------------------------------------
  // Write channel decode
  // ----------------------------------------------------------------

  // Both halves held and no response pending: commit now
  wire wr_fire = ~awready & ~wready & ~bvalid;
  wire [3:0] wr_idx = acs_decode(wr_addr);
  wire wr_hit = wr_idx != ACS_IDX_NONE;
  // All writable fields live in byte lane 0
  wire wr_lane0 = wr_fire & wr_strb[0];
  wire wr_ctrl = wr_lane0 & (wr_idx == ACS_IDX_CTRL);
  wire wr_stat = wr_lane0 & (wr_idx == ACS_IDX_STATUS);
  wire wr_mask = wr_lane0 & (wr_idx == ACS_IDX_MASK);
  // One-to-clear pattern for the status register
  wire [ACS_STAT_W-1:0] stat_clr =
    wr_stat ? wr_data[ACS_STAT_W-1:0] : ACS_STAT_RST;
  wire [ACS_STAT_W-1:0] stat_set = {trap_evt, set_b, set_a};
  // Hardware set wins over a clear in the same cycle
  wire [ACS_STAT_W-1:0] next_status =
    (status & ~stat_clr) | stat_set;

  // ----------------------------------------------------------------
  // Read channel decode
  // ----------------------------------------------------------------
  wire [3:0] rd_idx = acs_decode(araddr);
  wire rd_hit = rd_idx != ACS_IDX_NONE;
  logic [31:0] rd_word;

  // Read data selection; unmapped reads return zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (rd_idx == ACS_IDX_CTRL)
      rd_word[ACS_CTRL_W-1:0] = ctrl;
    else if (rd_idx == ACS_IDX_STATUS)
      rd_word[ACS_STAT_W-1:0] = status;
    else if (rd_idx == ACS_IDX_MASK)
      rd_word[ACS_STAT_W-1:0] = mask;
    else if (rd_idx == ACS_IDX_FLAGS)
      rd_word[5:0] = flags;
    else if (rd_idx == ACS_IDX_ACCA_LO)
      rd_word = acc_a[31:0];
    else if (rd_idx == ACS_IDX_ACCA_HI)
      rd_word[7:0] = acc_a[ACS_ACC_W-1:32];
    else if (rd_idx == ACS_IDX_ACCB_LO)
      rd_word = acc_b[31:0];
    else if (rd_idx == ACS_IDX_ACCB_HI)
      rd_word[7:0] = acc_b[ACS_ACC_W-1:32];
  end

  // Next flag outputs, combined bits formed from next values
  wire next_ovf_a = (res_valid & ~res.target) ? ovf_evt : ovf_a;
  wire next_ovf_b = (res_valid & res.target) ? ovf_evt : ovf_b;
  wire [ACS_STAT_W-1:0] next_mask =
    wr_mask ? wr_data[ACS_STAT_W-1:0] : mask;
  wire [ACS_STAT_W-1:0] next_pend = next_status & next_mask;

  // ----------------------------------------------------------------
  // AXI4-Lite write address and data capture
  // ----------------------------------------------------------------

  // Ready drops on capture; rises again after the response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wr_addr <= '0;
    end
    else if (awvalid && awready)
    begin
      awready <= 1'b0;
      wr_addr <= awaddr;
    end
    else if (bvalid && bready)
      awready <= 1'b1;
  end

  // Data captured independently of the address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready <= 1'b1;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      wready <= 1'b0;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end
    else if (bvalid && bready)
      wready <= 1'b1;
  end

  // Response one cycle after both halves are held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= ACS_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read
  // ----------------------------------------------------------------

  // Single outstanding read; data latched with the address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= ACS_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_hit ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------

  // Control, mask and sticky status
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= ACS_CTRL_RST;
      mask <= ACS_MASK_RST;
      status <= ACS_STAT_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= wr_data[ACS_CTRL_W-1:0];
      mask <= next_mask;
      status <= next_status;
    end
  end

  // ----------------------------------------------------------------
  // Accumulators
  // ----------------------------------------------------------------

  // Loaded with the clamped or wrapped result of each pass
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc_a <= '0;
      acc_b <= '0;
    end
    else if (res_valid)
    begin
      if (res.target)
        acc_b <= sat_result;
      else
        acc_a <= sat_result;
    end
  end

  // ----------------------------------------------------------------
  // Flags, trap and interrupt outputs
  // ----------------------------------------------------------------

  // Overflow flags follow each pass; clamped flags mirror status
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ovf_a <= 1'b0;
      ovf_b <= 1'b0;
      flags <= '0;
    end
    else
    begin
      ovf_a <= next_ovf_a;
      ovf_b <= next_ovf_b;
      flags.acc_a_clamped <= next_status[0];
      flags.acc_b_clamped <= next_status[1];
      flags.acc_a_overflow <= next_ovf_a;
      flags.acc_b_overflow <= next_ovf_b;
      flags.either_acc_overflow <= next_ovf_a | next_ovf_b;
      flags.either_acc_clamped <= next_status[0] | next_status[1];
    end
  end

  // Trap request is a one-cycle pulse per catastrophic pass
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trap_req <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      trap_req <= trap_evt;
      // Level interrupt tracks unmasked sticky bits
      irq <= |next_pend;
    end
  end

endmodule

// >>> pkg/acs_pkg.sv
// Shared constants, types and register map of the accumulator saturation block
package acs_pkg;

  // ----------------------------------------------------------------
  // Datapath widths and bit positions
  // ----------------------------------------------------------------
  localparam int ACS_ACC_W = 40;  // 9.31 accumulator
  localparam int ACS_SUM_W = 41;  // Adder result with one carry bit
  localparam int ACS_BIT31 = 31;  // 1.31 sign position
  localparam int ACS_BIT39 = 39;  // 9.31 sign position

  // Clamp limits
  localparam logic [39:0] ACS_MAX_939 = 40'h7f_ffff_ffff;
  localparam logic [39:0] ACS_MIN_939 = 40'h80_0000_0000;
  localparam logic [39:0] ACS_MAX_131 = 40'h00_7fff_ffff;
  localparam logic [39:0] ACS_MIN_131 = 40'hff_8000_0000;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and field positions
  // ----------------------------------------------------------------
  localparam int ACS_ADDR_W = 6;
  localparam logic [5:0] ACS_OFF_CTRL = 6'h00;
  localparam logic [5:0] ACS_OFF_STATUS = 6'h04;
  localparam logic [5:0] ACS_OFF_MASK = 6'h08;
  localparam logic [5:0] ACS_OFF_FLAGS = 6'h0c;
  localparam logic [5:0] ACS_OFF_ACCA_LO = 6'h10;
  localparam logic [5:0] ACS_OFF_ACCA_HI = 6'h14;
  localparam logic [5:0] ACS_OFF_ACCB_LO = 6'h18;
  localparam logic [5:0] ACS_OFF_ACCB_HI = 6'h1c;

  // Register indices returned by the address decoder
  localparam logic [3:0] ACS_IDX_CTRL = 4'h0;
  localparam logic [3:0] ACS_IDX_STATUS = 4'h1;
  localparam logic [3:0] ACS_IDX_MASK = 4'h2;
  localparam logic [3:0] ACS_IDX_FLAGS = 4'h3;
  localparam logic [3:0] ACS_IDX_ACCA_LO = 4'h4;
  localparam logic [3:0] ACS_IDX_ACCA_HI = 4'h5;
  localparam logic [3:0] ACS_IDX_ACCB_LO = 4'h6;
  localparam logic [3:0] ACS_IDX_ACCB_HI = 4'h7;
  localparam logic [3:0] ACS_IDX_NONE = 4'hf;

  // Control: [0] sat en A, [1] sat en B, [2] 40-bit limit, [3] trap en
  localparam int ACS_CTRL_W = 4;
  localparam logic [3:0] ACS_CTRL_RST = 4'h0;
  // Status/mask: [0] A clamped, [1] B clamped, [2] wrap trap seen
  localparam int ACS_STAT_W = 3;
  localparam logic [2:0] ACS_STAT_RST = 3'h0;
  localparam logic [2:0] ACS_MASK_RST = 3'h0;

  localparam logic [1:0] ACS_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACS_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACS_MODE_WRAP = 2'b00,  // No clamping, catastrophic overflow
    ACS_MODE_SAT31 = 2'b01,  // Clamp at 1.31 limits
    ACS_MODE_SAT39 = 2'b10  // Clamp at 9.31 limits
  } acs_mode_e;

  typedef struct packed {
    logic target;  // 0 = accumulator A, 1 = accumulator B
    logic [40:0] sum;  // Raw adder/subtracter result
  } acs_result_s;

  typedef struct packed {
    logic acc_a_clamped;
    logic acc_b_clamped;
    logic acc_a_overflow;
    logic acc_b_overflow;
    logic either_acc_overflow;
    logic either_acc_clamped;
  } acs_flags_s;

endpackage

// >>> hw/acs_sat_unit.sv
// Combinational clamp or wrap of one adder result into a 40-bit accumulator
`timescale 1ns/1ps
module acs_sat_unit
  import acs_pkg::*;
(
  // Adder result and selected mode
  input wire logic [ACS_SUM_W-1:0] sum,
  input wire acs_mode_e mode,
  // Value to load and events
  output logic [ACS_ACC_W-1:0] result,
  output logic clamp_evt,
  output logic ovf_flag
);

  // Sign of the true result sits in the carry bit
  wire sign = sum[ACS_SUM_W-1];
  // Carry disagrees with bit 39: value left the 9.31 range
  wire ovf39 = sum[ACS_SUM_W-1] ^ sum[ACS_BIT39];
  // Bits 40..31 not all equal: guard bits carry magnitude
  wire top_ones = &sum[ACS_SUM_W-1:ACS_BIT31];
  wire top_zeros = ~(|sum[ACS_SUM_W-1:ACS_BIT31]);
  wire ovf31 = ~(top_ones | top_zeros);
  // Same test on the wrapped 40-bit value
  wire wrap_ones = &sum[ACS_BIT39:ACS_BIT31];
  wire wrap_zeros = ~(|sum[ACS_BIT39:ACS_BIT31]);
  wire wrap_ovf = ~(wrap_ones | wrap_zeros);
  // Limits picked by sign of the true result
  wire [ACS_ACC_W-1:0] lim39 = sign ? ACS_MIN_939 : ACS_MAX_939;
  wire [ACS_ACC_W-1:0] lim31 = sign ? ACS_MIN_131 : ACS_MAX_131;

  // Mode selects clamp limit and flag sources
  always_comb
  begin
    result = sum[ACS_ACC_W-1:0];
    clamp_evt = 1'b0;
    ovf_flag = 1'b0;
    case (mode)
      ACS_MODE_SAT39:
      begin
        result = ovf39 ? lim39 : sum[ACS_ACC_W-1:0];
        clamp_evt = ovf39;
        ovf_flag = ovf31;
      end
      ACS_MODE_SAT31:
      begin
        result = ovf31 ? lim31 : sum[ACS_ACC_W-1:0];
        clamp_evt = ovf31;
        // Guard bits unused here, so overflow never reported
        ovf_flag = 1'b0;
      end
      default:
      begin
        // Wrap freely; sign may be destroyed
        result = sum[ACS_ACC_W-1:0];
        clamp_evt = ovf39;
        ovf_flag = wrap_ovf;
      end
    endcase
  end

endmodule

// >>> dv/acs_adder_model.sv
// Behavioural adder/subtracter that feeds results into the saturation block
`timescale 1ns/1ps
module acs_adder_model
  import acs_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Result towards the block
  output logic res_valid,
  output acs_result_s res
);
  // ----------------------------------------------------------------
  // Result driver
  // ----------------------------------------------------------------
  // Nothing is offered at start
  initial
  begin
    res_valid = 1'b0;
    res = '0;
  end

  // Offer one result per edge, so calls may follow back to back
  task automatic push(input logic tgt, input logic [40:0] s);
    @(posedge aclk);
    res_valid <= 1'b1;
    res <= '{target: tgt, sum: s};
  endtask

  // Release; payload inverted so stale data never looks valid
  task automatic idle();
    @(posedge aclk);
    res_valid <= 1'b0;
    res <= ~res;
  endtask
endmodule

// >>> dv/acs_top_sva.sv
// Assertion checker for the accumulator saturation block
`timescale 1ns/1ps
module acs_top_sva
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus write side
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [ACS_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [31:0] wdata,
  input wire logic bvalid,
  input wire logic [1:0] bresp,
  // Result and outputs
  input wire logic res_valid,
  input wire acs_result_s res,
  input wire logic [ACS_ACC_W-1:0] acc_a,
  input wire acs_flags_s flags,
  input wire logic trap_req
);
  // ----------------------------------------------------------------
  // Shadow of the control register
  // ----------------------------------------------------------------
  logic [5:0] wa; // Captured write address
  logic [3:0] wd; // Captured control bits
  logic [3:0] ctrl; // Lags the real one by one edge
  logic bv_d; // Response valid, delayed
  always_ff @(posedge aclk)
  begin
    if (awvalid && awready)
      wa <= awaddr;
    if (wvalid && wready)
      wd <= wdata[3:0];
    bv_d <= bvalid && aresetn;
    if (!aresetn)
      ctrl <= 4'h0;
    else if (bvalid && !bv_d && bresp == ACS_RESP_OKAY && wa == ACS_OFF_CTRL)
      ctrl <= wd;
  end

  // Mode and overflow decode for results aimed at accumulator A
  wire logic tgt_a = res_valid && !res.target;
  wire logic ovf39 = res.sum[40] ^ res.sum[39];
  wire logic ovf31 = |res.sum[40:31] && !(&res.sum[40:31]);
  wire logic wrap_a = tgt_a && !ctrl[0];
  wire logic sat39_a = tgt_a && ctrl[0] && ctrl[2];
  wire logic sat31_a = tgt_a && ctrl[0] && !ctrl[2];

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wrap_ovf_a;
    wrap_a && ovf39;
  endsequence
  property p_reset;
    $rose(aresetn) |-> flags == '0 && !trap_req;
  endproperty
  property p_or_ovf;
    flags.either_acc_overflow == (flags.acc_a_overflow | flags.acc_b_overflow);
  endproperty
  property p_or_clamp;
    flags.either_acc_clamped == (flags.acc_a_clamped | flags.acc_b_clamped);
  endproperty
  // Only a software write may clear a clamped flag
  property p_sticky;
    $fell(flags.acc_a_clamped) |-> $rose(bvalid);
  endproperty
  property p_wrap;
    wrap_a |=> acc_a == $past(res.sum[39:0]);
  endproperty
  property p_wrap_flag;
    s_wrap_ovf_a |=> flags.acc_a_clamped;
  endproperty
  property p_trap;
    s_wrap_ovf_a ##0 ctrl[3] |=> trap_req;
  endproperty
  property p_in_range;
    sat39_a && !ovf39 |=> acc_a == $past(res.sum[39:0]);
  endproperty
  property p_sat39;
    sat39_a && ovf39 |=> flags.acc_a_clamped &&
      acc_a == ($past(res.sum[40]) ? ACS_MIN_939 : ACS_MAX_939);
  endproperty
  property p_sat31;
    sat31_a && ovf31 |=> flags.acc_a_clamped &&
      acc_a == ($past(res.sum[40]) ? ACS_MIN_131 : ACS_MAX_131);
  endproperty
  property p_no_ovf31;
    sat31_a |=> !flags.acc_a_overflow;
  endproperty

  a_reset: assert property (p_reset)
    else $error("flags or trap set after reset");
  a_or_ovf: assert property (p_or_ovf)
    else $error("combined overflow wrong");
  a_or_clamp: assert property (p_or_clamp)
    else $error("combined clamped wrong");
  a_sticky: assert property (p_sticky)
    else $error("clamped cleared without a write");
  a_wrap: assert property (p_wrap)
    else $error("wrap result altered");
  a_wrap_flag: assert property (p_wrap_flag)
    else $error("wrap overflow not flagged");
  a_trap: assert property (p_trap)
    else $error("trap not raised");
  a_in_range: assert property (p_in_range)
    else $error("in-range value clamped");
  a_sat39: assert property (p_sat39)
    else $error("40-bit clamp wrong");
  a_sat31: assert property (p_sat31)
    else $error("32-bit clamp wrong");
  a_no_ovf31: assert property (p_no_ovf31)
    else $error("overflow set in 32-bit mode");
endmodule

bind acs_top acs_top_sva u_sva (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
  .wvalid(wvalid), .wready(wready), .wdata(wdata), .bvalid(bvalid),
  .bresp(bresp), .res_valid(res_valid), .res(res), .acc_a(acc_a),
  .flags(flags), .trap_req(trap_req));

// >>> dv/acs_top_tb_top.sv
// Self-checking bench for the accumulator saturation block
`timescale 1ns/1ps
module acs_top_tb_top
  import acs_pkg::*;
;
  // One result case: control, target, sum and what must follow
  typedef struct packed {
    logic [3:0] ctrl;
    logic tgt;
    logic [40:0] sum;
    logic [39:0] acc;
    logic cl;
    logic ov;
  } acs_case_s;
  acs_case_s tc [10] = '{
    '{4'h0, 1'b0, 41'h080_0000_0000, 40'h80_0000_0000, 1'b1, 1'b1},
    '{4'h8, 1'b1, 41'h17f_ffff_ffff, 40'h7f_ffff_ffff, 1'b1, 1'b1},
    '{4'h5, 1'b0, 41'h080_0000_0000, 40'h7f_ffff_ffff, 1'b1, 1'b1},
    '{4'h5, 1'b0, 41'h100_0000_0000, 40'h80_0000_0000, 1'b1, 1'b1},
    '{4'h2, 1'b1, 41'h000_8000_0000, 40'h00_7fff_ffff, 1'b1, 1'b0},
    '{4'h2, 1'b1, 41'h1ff_7fff_ffff, 40'hff_8000_0000, 1'b1, 1'b0},
    '{4'h1, 1'b0, 41'h000_8000_0000, 40'h00_7fff_ffff, 1'b1, 1'b0},
    '{4'h1, 1'b0, 41'h1ff_7fff_ffff, 40'hff_8000_0000, 1'b1, 1'b0},
    '{4'h5, 1'b0, 41'h000_8000_0000, 40'h00_8000_0000, 1'b0, 1'b1},
    '{4'h8, 1'b0, 41'h000_0000_1234, 40'h00_0000_1234, 1'b0, 1'b0}};

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [5:0] awaddr = 6'h00;
  logic [5:0] araddr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, res_valid, trap_req, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [39:0] acc_a, acc_b;
  acs_result_s res;
  acs_flags_s flags;
  logic [1:0] ovf; // Expected overflow flag of each accumulator
  int errors = 0;
  int samples_checked = 0;

  // 20 MHz clock
  always #25 aclk = ~aclk;

  acs_top dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rresp_unused_guard(2'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .res_valid(res_valid), .res(res), .acc_a(acc_a), .acc_b(acc_b),
    .flags(flags), .trap_req(trap_req), .irq(irq));

  acs_adder_model u_adr (.aclk(aclk), .res_valid(res_valid), .res(res));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask

  // Write; address and data each dropped once taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'b1;
    while (!(ta && tw))
    begin
      @(posedge aclk);
      ta = ta | awready;
      tw = tw | wready;
      awvalid <= !ta;
      wvalid <= !tw;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask

  // Read and compare data and response
  task automatic rd(input logic [5:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", ed, rdata);
    chk("rresp", er, rresp);
  endtask

  // Interrupt is registered, so look one edge later
  task automatic irq_is(input logic e);
    @(posedge aclk);
    #1;
    chk("irq", e, irq);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    ovf = 2'b00;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    chk("trap", 0, trap_req);
    for (int i = 0; i < 16; i += 4)
      rd(i[5:0], 0, ACS_RESP_OKAY);
    wr(6'h20, 32'h1, ACS_RESP_SLVERR);
    rd(6'h24, 0, ACS_RESP_SLVERR);
    // Every mode, both limits and both signs
    foreach (tc[i])
    begin
      wr(ACS_OFF_CTRL, {28'h0, tc[i].ctrl}, ACS_RESP_OKAY);
      wr(ACS_OFF_STATUS, 32'h7, ACS_RESP_OKAY);
      u_adr.push(tc[i].tgt, tc[i].sum);
      u_adr.idle();
      #1;
      ovf[tc[i].tgt] = tc[i].ov;
      chk("acc", tc[i].acc, tc[i].tgt ? acc_b : acc_a);
      chk("clamped", tc[i].cl, flags[5-tc[i].tgt]);
      chk("overflow", tc[i].ov, flags[3-tc[i].tgt]);
      chk("either_ovf", ovf[0] | ovf[1], flags.either_acc_overflow);
      chk("either_clamped", tc[i].cl, flags.either_acc_clamped);
      chk("trap", tc[i].ctrl[3] & tc[i].cl, trap_req);
      @(posedge aclk);
      #1;
      chk("trap", 0, trap_req);
    end
    // Overflow then in-range result back to back: flag stays
    u_adr.push(1'b0, 41'h080_0000_0000);
    u_adr.push(1'b0, 41'h000_0000_0005);
    u_adr.idle();
    #1;
    chk("sticky", 1, flags.acc_a_clamped);
    chk("acc_a", 40'h5, acc_a);
    rd(ACS_OFF_STATUS, 32'h5, ACS_RESP_OKAY);
    rd(ACS_OFF_FLAGS, 32'h21, ACS_RESP_OKAY);
    rd(ACS_OFF_ACCB_LO, 32'h8000_0000, ACS_RESP_OKAY);
    rd(ACS_OFF_ACCB_HI, 32'hff, ACS_RESP_OKAY);
    // Interrupt raised, masked and cleared
    wr(ACS_OFF_MASK, 32'h1, ACS_RESP_OKAY);
    irq_is(1'b1);
    wr(ACS_OFF_MASK, 32'h2, ACS_RESP_OKAY);
    irq_is(1'b0);
    rd(ACS_OFF_MASK, 32'h2, ACS_RESP_OKAY);
    wr(ACS_OFF_MASK, 32'h1, ACS_RESP_OKAY);
    wr(ACS_OFF_STATUS, 32'h1, ACS_RESP_OKAY);
    irq_is(1'b0);
    chk("cleared", 0, flags.acc_a_clamped);
    end_of_test();
  end

  // Watchdog well beyond the 172 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge aclk);
    errors++;
    end_of_test();
  end
endmodule
